/* rtl/lpb_pkg.sv */
// package: register map, field layouts and level presets of the parallel bus decoder
`default_nettype none
package lpb_pkg;
	localparam int NumIn    = 16;            // logic inputs, two pods of eight
	localparam int LvlW     = 11;            // signed level code, 10 mV per step
	localparam int SrcW     = 4;             // input selector width
	localparam int CntW     = 16;            // trigger width/timeout counter
	localparam int LblWords = 2 * NumIn;     // two words of label per input
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_SRC_LO  = 8'h04;
	localparam logic [7:0] ADDR_SRC_HI  = 8'h08;
	localparam logic [7:0] ADDR_SEL     = 8'h0c;
	localparam logic [7:0] ADDR_THR     = 8'h10;  // four words, one per nibble
	localparam logic [7:0] ADDR_TRIG    = 8'h20;
	localparam logic [7:0] ADDR_PAT     = 8'h24;
	localparam logic [7:0] ADDR_TLIM    = 8'h28;
	localparam logic [7:0] ADDR_STAT    = 8'h2c;
	localparam logic [7:0] ADDR_WORD    = 8'h30;
	localparam logic [7:0] ADDR_TIME    = 8'h34;
	localparam logic [7:0] ADDR_LBL     = 8'h40;
	localparam logic [7:0] ADDR_LBL_END = 8'hbc;
	// field positions
	localparam int STAT_AVAIL = 16;
	localparam int STAT_TRIG  = 17;
	localparam int STAT_OVF   = 18;
	localparam int SEL_CLK    = 0;
	localparam int SEL_CS     = 4;
	// levels in 10 mV steps
	localparam logic [LvlW-1:0] LVL_TTL  = 11'h08c;  // 1.4 V
	localparam logic [LvlW-1:0] LVL_CMOS = 11'h0fa;  // 2.5 V
	localparam logic [LvlW-1:0] LVL_ECL  = 11'h77e;  // -1.3 V
	localparam logic [LvlW-1:0] LVL_MIN  = 11'h738;  // -2 V
	localparam logic [LvlW-1:0] LVL_MAX  = 11'h320;  // +8 V
	localparam logic [7:0] CHAR_MIN  = 8'h20;
	localparam logic [7:0] CHAR_MAX  = 8'h7e;
	localparam logic [4:0] WIDTH_MAX = 5'h10;
	localparam logic [31:0] CTRL_RST = 32'h0000_1060;  // both pods on, 16 bits
	localparam logic [31:0] THR_RST  = 32'h0005_0000;  // TTL, hysteresis 50 mV
	typedef enum logic [1:0] {SLOPE_RISE, SLOPE_FALL, SLOPE_BOTH, SLOPE_RSV} slope_t;
	typedef enum logic [1:0] {TECH_TTL, TECH_CMOS, TECH_ECL, TECH_USER} tech_t;
	typedef enum logic [1:0] {TRIG_EDGE, TRIG_WIDTH, TRIG_PATTERN, TRIG_TIMEOUT} trig_kind_t;
	typedef struct packed {
		logic [13:0] rsv2;
		logic        couple;
		logic        defOrder;
		logic [2:0]  rsv1;
		logic [4:0]  width;
		logic        rsv0;
		logic        pod1;
		logic        pod0;
		slope_t      slope;
		logic        csPol;
		logic        csEn;
		logic        clocked;
	} ctrl_t;
	typedef struct packed {
		logic [7:0]      rsv2;
		logic [7:0]      hyst;
		logic [1:0]      rsv1;
		tech_t           tech;
		logic            rsv0;
		logic [LvlW-1:0] user;
	} thr_t;
	typedef struct packed {
		logic [24:0] rsv;
		logic        rising;
		trig_kind_t  kind;
		logic [3:0]  src;
	} trig_t;
endpackage : lpb_pkg
`default_nettype wire

/* rtl/logic_parallel_bus_decoder.sv */
// parallel bus decoder: thresholds, bit mapping, clocked capture, trigger, APB registers
// How it works
// - bus width one to sixteen bits
// - each bus bit selects any input
// - clocked mode adds clock and select inputs
// - default order maps bit n to input n
// - select line use can be switched off
// - select line active high or low
// - sample on rise, fall or both edges
// - each qualifying clock edge starts a word
// - one threshold per four-input group
// - couple copies group zero to all groups
// - user threshold -2 V to +8 V, 10 mV
// - presets 1.4 V, 2.5 V, -1.3 V or user
// - hysteresis band stops noise toggling states
// - each eight-input pod enabled separately
// - trigger uses the input threshold level
// - edge, width, pattern and timeout triggers
// - record word with its start time
// - labels of eight permitted characters
// - sixteen inputs as two pods of eight
`default_nettype none
module logic_parallel_bus_decoder
	import lpb_pkg::*;
#(
	parameter int TimeW = 32  // timestamp width
) (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic [NumIn-1:0][LvlW-1:0]   probeLevel,  // per-input level codes
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	output logic      [NumIn-1:0]             logicState,
	output logic                              wordValid,
	output logic      [NumIn-1:0]             wordData,
	output logic      [TimeW-1:0]             wordTime,
	output logic                              trigPulse
);
	// threshold of one group, preset or user value
	function automatic logic [LvlW-1:0] thrLevel(input thr_t t);
		unique case (t.tech)
			TECH_TTL:  thrLevel = LVL_TTL;
			TECH_CMOS: thrLevel = LVL_CMOS;
			TECH_ECL:  thrLevel = LVL_ECL;
			TECH_USER: thrLevel = t.user;
		endcase
	endfunction : thrLevel

	// keep a user level inside the accepted span
	function automatic logic [LvlW-1:0] clampLvl(input logic [LvlW-1:0] v);
		if ($signed(v) < $signed(LVL_MIN))
			clampLvl = LVL_MIN;
		else if ($signed(v) > $signed(LVL_MAX))
			clampLvl = LVL_MAX;
		else
			clampLvl = v;
	endfunction : clampLvl

	// every byte is printable or zero, in any position
	function automatic logic charsOk(input logic [31:0] w);
		logic [7:0] c;
		charsOk = 1'b1;
		for (int k = 0; k < 4; k++) begin
			c = w[8*k +: 8];
			if (c != 8'h00 && (c < CHAR_MIN || c > CHAR_MAX))
				charsOk = 1'b0;
		end
	endfunction : charsOk

	// address lies in the label window
	function automatic logic isLbl(input logic [7:0] a);
		isLbl = (a >= ADDR_LBL) && (a <= ADDR_LBL_END);
	endfunction : isLbl

	logic [NumIn-1:0]           stateReg, stateNext;      // detected logic levels
	ctrl_t                      ctrlReg, ctrlNext;        // mode and pod control
	logic [NumIn-1:0][SrcW-1:0] srcReg, srcNext;          // bit to input map
	logic [SrcW-1:0]            clkSelReg, clkSelNext;    // clock input
	logic [SrcW-1:0]            csSelReg, csSelNext;      // select input
	thr_t [3:0]                 thrReg, thrNext;          // nibble thresholds
	trig_t                      trigReg, trigNext;
	logic [31:0]                patReg, patNext;          // mask high, value low
	logic [CntW-1:0]            tlimReg, tlimNext;        // width/timeout limit
	logic [31:0]                lblReg [LblWords];        // channel labels
	logic [31:0]                lblNext [LblWords];
	logic [31:0]                prdataReg, prdataNext;
	logic                       preadyReg, preadyNext;
	logic                       errReg, errNext;
	logic [NumIn-1:0]           busWord, lastWordReg;
	logic                       clkPrevReg, trigPrevReg, matchPrevReg;
	logic [CntW-1:0]            cntReg, cntNext;
	logic [TimeW-1:0]           timeReg;                  // free running time base
	logic                       availReg, availNext;      // unread word sticky
	logic                       ovfReg, ovfNext;          // word lost sticky
	logic                       trigSeenReg, trigSeenNext;
	logic                       wordValidReg, trigPulseReg, fire, take, match;
	logic [NumIn-1:0]           wordDataReg;
	logic [TimeW-1:0]           wordTimeReg;
	logic                       wrEn, rdEn, popWord;
	logic [4:0]                 lblIdx;

	assign prdata     = prdataReg;
	assign pready     = preadyReg;
	assign pslverr    = errReg;
	assign logicState = stateReg;
	assign wordValid  = wordValidReg;
	assign wordData   = wordDataReg;
	assign wordTime   = wordTimeReg;
	assign trigPulse  = trigPulseReg;

	// a write or read lands only at the completing access edge
	assign wrEn    = psel & penable & preadyReg & pwrite & ~errReg;
	assign rdEn    = psel & penable & preadyReg & ~pwrite & ~errReg;
	assign popWord = rdEn && paddr == ADDR_WORD;
	assign lblIdx  = 5'((paddr - ADDR_LBL) >> 2);

	// comparators with hysteresis; the level codes arrive in the clk domain
	always_comb begin
		logic signed [12:0] th, hy, lv;
		th = '0;
		hy = '0;
		lv = '0;
		stateNext = stateReg;
		for (int i = 0; i < NumIn; i++) begin
			th = 13'($signed(thrLevel(thrReg[i/4])));
			hy = 13'($signed({1'b0, thrReg[i/4].hyst}));
			lv = 13'($signed(probeLevel[i]));
			// inside the band the old state holds
			if (lv >= th + hy)
				stateNext[i] = 1'b1;
			else if (lv < th - hy)
				stateNext[i] = 1'b0;
			// a pod that is off reads low
			if (!(i < 8 ? ctrlReg.pod0 : ctrlReg.pod1))
				stateNext[i] = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end

	// bus assembly from the bit map, bits above width read zero
	always_comb begin
		for (int b = 0; b < NumIn; b++)
			busWord[b] = (b < ctrlReg.width) && stateReg[srcReg[b]];
	end

	// frame detection, capture and trigger
	always_comb begin
		logic clkNow, rise, fall, edgeHit, csActive, tNow, tEdge;
		clkNow   = stateReg[clkSelReg];
		rise     = clkNow & ~clkPrevReg;
		fall     = ~clkNow & clkPrevReg;
		unique case (ctrlReg.slope)
			SLOPE_RISE: edgeHit = rise;
			SLOPE_FALL: edgeHit = fall;
			SLOPE_BOTH: edgeHit = rise | fall;
			default:    edgeHit = 1'b0;
		endcase
		csActive = stateReg[csSelReg] == ctrlReg.csPol;
		// data is taken from the same sampled cycle as the clock edge
		if (ctrlReg.clocked)
			take = edgeHit & (~ctrlReg.csEn | csActive);
		else
			take = busWord != lastWordReg;
		// the word is read in the same cycle a new one lands: keep it set
		availNext = take | (availReg & ~popWord);
		ovfNext   = (take & availReg & ~popWord) | (ovfReg & ~(wrEn && paddr == ADDR_STAT && pwdata[STAT_OVF]));
		// trigger works on the thresholded state
		tNow  = stateReg[trigReg.src];
		tEdge = tNow ^ trigPrevReg;
		match = ((stateReg ^ patReg[15:0]) & patReg[31:16] & {{8{ctrlReg.pod1}}, {8{ctrlReg.pod0}}}) == '0;
		cntNext = cntReg;
		fire    = 1'b0;
		unique case (trigReg.kind)
			TRIG_EDGE: begin
				fire = tEdge & (tNow == trigReg.rising);
			end
			TRIG_WIDTH: begin
				// pulse at the chosen level at least the limit long
				cntNext = (tNow == trigReg.rising) ? ((&cntReg) ? cntReg : cntReg + 1'b1) : '0;
				fire    = tEdge & (tNow != trigReg.rising) & (cntReg >= tlimReg);
			end
			TRIG_PATTERN: begin
				fire = match & ~matchPrevReg;
			end
			TRIG_TIMEOUT: begin
				// no edge for the limit count fires once
				cntNext = tEdge ? '0 : ((cntReg == tlimReg) ? cntReg : cntReg + 1'b1);
				fire    = (cntReg != tlimReg) & (cntNext == tlimReg);
			end
		endcase
		trigSeenNext = fire | (trigSeenReg & ~(wrEn && paddr == ADDR_STAT && pwdata[STAT_TRIG]));
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clkPrevReg   <= 1'b0;
			trigPrevReg  <= 1'b0;
			matchPrevReg <= 1'b0;
			lastWordReg  <= '0;
			cntReg       <= '0;
			timeReg      <= '0;
			availReg     <= 1'b0;
			ovfReg       <= 1'b0;
			trigSeenReg  <= 1'b0;
			wordValidReg <= 1'b0;
			trigPulseReg <= 1'b0;
			wordDataReg  <= '0;
			wordTimeReg  <= '0;
		end else begin
			clkPrevReg   <= stateReg[clkSelReg];
			trigPrevReg  <= stateReg[trigReg.src];
			matchPrevReg <= match;
			lastWordReg  <= busWord;
			cntReg       <= cntNext;
			timeReg      <= timeReg + 1'b1;
			availReg     <= availNext;
			ovfReg       <= ovfNext;
			trigSeenReg  <= trigSeenNext;
			wordValidReg <= take;
			trigPulseReg <= fire;
			if (take) begin
				wordDataReg <= busWord;
				wordTimeReg <= timeReg;
			end
		end
	end

	// apb slave: answer registered in setup, one access cycle, no waits
	always_comb begin
		ctrl_t wc;
		thr_t  wt;
		logic  hit;
		wc         = ctrl_t'(pwdata);
		wt         = thr_t'(pwdata);
		hit        = 1'b1;
		ctrlNext   = ctrlReg;
		srcNext    = srcReg;
		clkSelNext = clkSelReg;
		csSelNext  = csSelReg;
		thrNext    = thrReg;
		trigNext   = trigReg;
		patNext    = patReg;
		tlimNext   = tlimReg;
		lblNext    = lblReg;
		prdataNext = '0;
		// read mux, also flags unmapped addresses
		if (paddr == ADDR_CTRL)
			prdataNext = 32'(ctrlReg);
		else if (paddr == ADDR_SRC_LO)
			prdataNext = 32'(srcReg[7:0]);
		else if (paddr == ADDR_SRC_HI)
			prdataNext = 32'(srcReg[15:8]);
		else if (paddr == ADDR_SEL)
			prdataNext = 32'({csSelReg, clkSelReg});
		else if (paddr[7:4] == ADDR_THR[7:4])
			prdataNext = 32'(thrReg[paddr[3:2]]);
		else if (paddr == ADDR_TRIG)
			prdataNext = 32'(trigReg);
		else if (paddr == ADDR_PAT)
			prdataNext = patReg;
		else if (paddr == ADDR_TLIM)
			prdataNext = 32'(tlimReg);
		else if (paddr == ADDR_STAT)
			prdataNext = {13'h0000, ovfReg, trigSeenReg, availReg, stateReg};
		else if (paddr == ADDR_WORD)
			prdataNext = 32'(wordDataReg);
		else if (paddr == ADDR_TIME)
			prdataNext = 32'(wordTimeReg);
		else if (isLbl(paddr))
			prdataNext = lblReg[lblIdx];
		else
			hit = 1'b0;
		preadyNext = psel & ~penable;
		// refuse unmapped, misaligned and bad label text
		errNext    = preadyNext & (~hit | (paddr[1:0] != 2'h0) | (pwrite & isLbl(paddr) & ~charsOk(pwdata)));
		if (!preadyNext || pwrite)
			prdataNext = '0;
		if (wrEn) begin
			if (paddr == ADDR_CTRL) begin
				ctrlNext          = wc;
				ctrlNext.rsv0     = 1'b0;
				ctrlNext.rsv1     = '0;
				ctrlNext.rsv2     = '0;
				ctrlNext.defOrder = 1'b0;
				ctrlNext.couple   = 1'b0;
				// width held to one through sixteen
				if (wc.width == 5'h00)
					ctrlNext.width = 5'h01;
				else if (wc.width > WIDTH_MAX)
					ctrlNext.width = WIDTH_MAX;
				if (wc.defOrder) begin
					for (int n = 0; n < NumIn; n++)
						srcNext[n] = SrcW'(n);
				end
				if (wc.couple) begin
					for (int g = 1; g < 4; g++)
						thrNext[g] = thrReg[0];
				end
			end else if (paddr == ADDR_SRC_LO)
				srcNext[7:0] = pwdata;
			else if (paddr == ADDR_SRC_HI)
				srcNext[15:8] = pwdata;
			else if (paddr == ADDR_SEL) begin
				clkSelNext = pwdata[SEL_CLK +: SrcW];
				csSelNext  = pwdata[SEL_CS +: SrcW];
			end else if (paddr[7:4] == ADDR_THR[7:4]) begin
				wt.rsv0 = 1'b0;
				wt.rsv1 = '0;
				wt.rsv2 = '0;
				wt.user = clampLvl(wt.user);
				thrNext[paddr[3:2]] = wt;
			end else if (paddr == ADDR_TRIG) begin
				trigNext     = trigger_clean(pwdata);
			end else if (paddr == ADDR_PAT)
				patNext = pwdata;
			else if (paddr == ADDR_TLIM)
				tlimNext = pwdata[CntW-1:0];
			else if (isLbl(paddr))
				lblNext[lblIdx] = pwdata;
		end
	end

	// trigger word with reserved bits dropped
	function automatic trig_t trigger_clean(input logic [31:0] w);
		trigger_clean     = trig_t'(w);
		trigger_clean.rsv = '0;
	endfunction : trigger_clean

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlReg   <= ctrl_t'(CTRL_RST);
			for (int n = 0; n < NumIn; n++)
				srcReg[n] <= SrcW'(n);
			clkSelReg <= '0;
			csSelReg  <= '0;
			for (int g = 0; g < 4; g++)
				thrReg[g] <= thr_t'(THR_RST);
			trigReg   <= '0;
			patReg    <= '0;
			tlimReg   <= '0;
			for (int k = 0; k < LblWords; k++)
				lblReg[k] <= '0;
			prdataReg <= '0;
			preadyReg <= 1'b0;
			errReg    <= 1'b0;
		end else begin
			ctrlReg   <= ctrlNext;
			srcReg    <= srcNext;
			clkSelReg <= clkSelNext;
			csSelReg  <= csSelNext;
			thrReg    <= thrNext;
			trigReg   <= trigNext;
			patReg    <= patNext;
			tlimReg   <= tlimNext;
			lblReg    <= lblNext;
			prdataReg <= prdataNext;
			preadyReg <= preadyNext;
			errReg    <= errNext;
		end
	end
endmodule : logic_parallel_bus_decoder
`default_nettype wire

/* tb/lpb_properties.sv */
// checker: port properties of the parallel bus decoder
`default_nettype none
module lpb_properties
	import lpb_pkg::*;
#(
	parameter int TimeW = 32  // timestamp width
) (
	input wire logic                       clk,
	input wire logic                       sys_rst,
	input wire logic [NumIn-1:0][LvlW-1:0] probeLevel,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [7:0]                 paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic [NumIn-1:0]           logicState,
	input wire logic                       wordValid,
	input wire logic [NumIn-1:0]           wordData,
	input wire logic [TimeW-1:0]           wordTime,
	input wire logic                       trigPulse
);
	ctrl_t            ctrlReg, ctrlNext;    // control shadow
	logic [63:0]      srcReg, srcNext;      // bit source shadow
	logic [7:0]       selReg, selNext;      // clock/select shadow
	logic [1:0]       quietReg, quietNext;  // edges since a write
	logic             wrOk;                 // accepted write
	logic [4:0]       w;                    // effective width
	logic [NumIn-1:0] mapped;               // bus as it should be
	logic             quiet;                // settings settled
	logic             ckBit;                // clock line state
	logic             csOff;                // select inactive
	// shadows follow accepted writes only
	always_comb begin
		wrOk = psel && penable && pready && pwrite && !pslverr;
		ctrlNext = ctrlReg;
		srcNext = srcReg;
		selNext = selReg;
		quietNext = (quietReg == 2'h3) ? quietReg : quietReg + 2'h1;
		if (wrOk) begin
			quietNext = 2'h0;
			if (paddr == ADDR_CTRL) ctrlNext = ctrl_t'(pwdata);
			if (paddr == ADDR_CTRL && pwdata[16]) srcNext = 64'hfedc_ba98_7654_3210;
			if (paddr == ADDR_SRC_LO) srcNext[31:0] = pwdata;
			if (paddr == ADDR_SRC_HI) srcNext[63:32] = pwdata;
			if (paddr == ADDR_SEL) selNext = pwdata[7:0];
		end
	end
	// shadow registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlReg <= ctrl_t'(CTRL_RST);
			srcReg <= 64'hfedc_ba98_7654_3210;
			selReg <= 8'h00;
			quietReg <= 2'h0;
		end else begin
			ctrlReg <= ctrlNext;
			srcReg <= srcNext;
			selReg <= selNext;
			quietReg <= quietNext;
		end
	end
	// expected assembly; width clamped as the block does
	always_comb begin
		w = (ctrlReg.width == 5'h00) ? 5'h01 : ((ctrlReg.width > WIDTH_MAX) ? WIDTH_MAX : ctrlReg.width);
		for (int i = 0; i < NumIn; i++) begin
			mapped[i] = (i < int'(w)) ? logicState[srcReg[4*i +: 4]] : 1'b0;
		end
		quiet = quietReg == 2'h3;
		ckBit = logicState[selReg[3:0]];
		csOff = logicState[selReg[7:4]] != ctrlReg.csPol;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	AST_POD_OFF: assert property (quiet && !ctrlReg.pod0 |-> logicState[7:0] == 8'h00)
		else $error("disabled pod shows a level");
	AST_WORD_HOLD: assert property (!wordValid |-> $stable(wordData) && $stable(wordTime))
		else $error("word changed without a pulse");
	AST_WIDTH: assert property (quiet && wordValid |-> (wordData >> w) == 16'h0000)
		else $error("bits beyond width set");
	AST_RISE: assert property (quiet && ctrlReg.clocked && !ctrlReg.csEn && ctrlReg.slope == SLOPE_RISE
		&& $rose(ckBit) |=> wordValid && wordData == $past(mapped))
		else $error("rising edge word wrong");
	AST_FALL: assert property (quiet && ctrlReg.clocked && ctrlReg.slope == SLOPE_FALL && !csOff
		&& $fell(ckBit) |=> wordValid)
		else $error("falling edge gave no word");
	AST_BOTH: assert property (quiet && ctrlReg.clocked && ctrlReg.slope == SLOPE_BOTH && !ctrlReg.csEn
		&& $changed(ckBit) |=> wordValid)
		else $error("double rate edge gave no word");
	AST_CS_BLOCK: assert property (quiet && ctrlReg.clocked && ctrlReg.csEn && csOff
		&& $changed(ckBit) |=> !wordValid)
		else $error("word while select inactive");
	AST_CS_PASS: assert property (quiet && ctrlReg.clocked && ctrlReg.csEn && !csOff
		&& ctrlReg.slope == SLOPE_RISE && $rose(ckBit) |=> wordValid)
		else $error("select active but no word");
	AST_UNCLK: assert property (quiet && !ctrlReg.clocked && $changed(mapped)
		|=> wordValid && wordData == $past(mapped))
		else $error("bus change gave no word");
endmodule : lpb_properties
bind logic_parallel_bus_decoder lpb_properties #(.TimeW(TimeW)) i_lpb_properties (
	.clk(clk), .sys_rst(sys_rst), .probeLevel(probeLevel), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.logicState(logicState), .wordValid(wordValid), .wordData(wordData), .wordTime(wordTime),
	.trigPulse(trigPulse)
);
`default_nettype wire

/* tb/lpb_far_logic.sv */
// far-side model: logic under test driving the probed lines
`default_nettype none
module lpb_far_logic
	import lpb_pkg::*;
(
	input  wire logic [LvlW-1:0]            lvlHi,      // level of a one
	input  wire logic [LvlW-1:0]            lvlLo,      // level of a zero
	output logic      [NumIn-1:0][LvlW-1:0] probeLevel  // levels at the probes
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [NumIn-1:0] lines = 16'h0000;  // 15 clock, 14 select
	// each line shows a high or low level
	always_comb begin
		for (int i = 0; i < NumIn; i++) begin
			probeLevel[i] = lines[i] ? lvlHi : lvlLo;
		end
	end
	// static lines, called on a clock edge
	task automatic setLines(input logic [NumIn-1:0] v);
		lines <= v;
	endtask : setLines
	// frame of n link periods of 64 ns; clock rests low between frames
	task automatic burst(input int n, input logic cs);
		#3 lines[14] = cs;
		repeat (n) begin
			#16 lines[15] = 1'b1;
			#16 lines[13:0] = lines[13:0] + 14'h0001;
			#16 lines[15] = 1'b0;
			#16 lines[13:0] = lines[13:0] + 14'h0001;
		end
	endtask : burst
endmodule : lpb_far_logic
`default_nettype wire

/* tb/logic_parallel_bus_decoder_tb.sv */
// testbench: register, threshold, decode and trigger tests
`default_nettype none
module logic_parallel_bus_decoder_tb import lpb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, sysRst, psel, penable, pwrite, pready, pslverr, wordValid, trigPulse;
	logic [7:0]                 paddr;          // apb address
	logic [31:0]                pwdata, prdata; // apb data
	logic [NumIn-1:0][LvlW-1:0] probeLevel;     // far side levels
	logic [LvlW-1:0]            lvlHi, lvlLo;   // levels of one and zero
	logic [NumIn-1:0]           logicState, wordData;
	logic [31:0]                wordTime, lastTime;
	int                         errors, samplesChecked, cyc, wordCnt, trigCnt;
	localparam logic [31:0] CtrlTab [6] = '{32'h861, 32'h869, 32'h871, 32'h867, 32'h867, 32'h863};
	localparam logic [5:0]  CsBits      = 6'h30;  // select level per row
	localparam int          CntTab [6]  = '{4, 4, 8, 0, 4, 0};
	localparam logic [31:0] TrigTab [4] = '{32'h40, 32'h60, 32'h50, 32'h70};
	localparam logic [31:0] TlimTab [4] = '{32'h0, 32'h0, 32'h3, 32'h14};
	logic_parallel_bus_decoder i_logic_parallel_bus_decoder (.clk(clk), .sys_rst(sysRst), .probeLevel(probeLevel),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .logicState(logicState), .wordValid(wordValid),
		.wordData(wordData), .wordTime(wordTime), .trigPulse(trigPulse));
	lpb_far_logic i_lpb_far_logic (.lvlHi(lvlHi), .lvlLo(lvlLo), .probeLevel(probeLevel));
	// clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// pulse counters and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wordValid === 1'b1) begin
			wordCnt <= wordCnt + 1;
			lastTime <= wordTime;
		end
		if (trigPulse === 1'b1) trigCnt <= trigCnt + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// apb transfer held until pready, then one idle cycle
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		r = prdata;
		e = pslverr;
		if (n == 16) chk("pready", 32'h1, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk($sformatf("reg %h", a), exp, r);
	endtask : rd
	// transfer that must be refused
	task automatic bad(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(w, a, d, r, e);
		chk($sformatf("slverr %h", a), 32'h1, {31'h0, e});
	endtask : bad
	// set the high level, let it settle, compare states
	task automatic lvl(input logic [LvlW-1:0] v, input logic [NumIn-1:0] exp);
		lvlHi <= v;
		repeat (3) @(posedge clk);
		chk("logicState", {16'h0, exp}, {16'h0, logicState});
	endtask : lvl
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	// main sequence
	initial begin
		int n;
		logic [31:0] t;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		lvlHi = 11'h1f4;
		lvlLo = 11'h000;
		sysRst = 1'b1;
		repeat (3) @(posedge clk);
		sysRst <= 1'b0;
		@(posedge clk);
		rd(ADDR_CTRL, CTRL_RST);
		rd(ADDR_THR + 8'h0c, THR_RST);
		rd(ADDR_SRC_HI, 32'hfedc_ba98);
		bad(1'b0, 8'hc0, 32'h0);
		bad(1'b0, 8'h02, 32'h0);
		bad(1'b1, ADDR_LBL, 32'h4142_4319);
		wr(ADDR_LBL + 8'h04, 32'h7e20_4142);
		rd(ADDR_LBL + 8'h04, 32'h7e20_4142);
		rd(ADDR_LBL, 32'h0);
		done("registers");
		i_lpb_far_logic.setLines(16'hffff);
		lvl(11'h091, 16'hffff);
		lvl(11'h087, 16'hffff);
		lvl(11'h086, 16'h0000);
		lvl(11'h090, 16'h0000);
		wr(ADDR_THR + 8'h04, 32'h0005_1000);
		wr(ADDR_THR + 8'h08, 32'h0005_2000);
		wr(ADDR_THR + 8'h0c, 32'h0005_312c);
		lvl(11'h0c8, 16'h0f0f);
		lvl(11'h780, 16'h0f00);
		lvl(11'h778, 16'h0000);
		wr(ADDR_CTRL, CTRL_RST | 32'h0002_0000);
		rd(ADDR_THR + 8'h0c, THR_RST);
		lvl(11'h0c8, 16'hffff);
		wr(ADDR_THR, 32'h0005_3400);
		rd(ADDR_THR, 32'h0005_3000 | {21'h0, LVL_MIN});
		wr(ADDR_THR, 32'h0005_33e8);
		rd(ADDR_THR, 32'h0005_3000 | {21'h0, LVL_MAX});
		wr(ADDR_THR, THR_RST);
		wr(ADDR_CTRL, 32'h0000_1020);
		lvl(11'h0c8, 16'h00ff);
		wr(ADDR_CTRL, 32'h0000_1040);
		lvl(11'h0c8, 16'hff00);
		done("levels");
		wr(ADDR_CTRL, 32'h0000_0460);
		wr(ADDR_SRC_LO, 32'h0000_ba98);
		i_lpb_far_logic.setLines(16'h0a00);
		repeat (4) @(posedge clk);
		chk("wordData", 32'ha, {16'h0, wordData});
		t = lastTime;
		n = wordCnt;
		i_lpb_far_logic.setLines(16'h05ff);
		repeat (4) @(posedge clk);
		chk("wordData", 32'h5, {16'h0, wordData});
		chk("wordTime", t + 32'h4, lastTime);
		chk("words", 32'(n + 1), 32'(wordCnt));
		rd(ADDR_WORD, 32'h5);
		wr(ADDR_CTRL, CTRL_RST | 32'h0001_0000);
		rd(ADDR_SRC_LO, 32'h7654_3210);
		done("unclocked");
		wr(ADDR_SEL, 32'h0000_00ef);
		for (int k = 0; k < 6; k++) begin
			wr(ADDR_CTRL, CtrlTab[k]);
			repeat (2) @(posedge clk);
			n = wordCnt;
			i_lpb_far_logic.burst(4, CsBits[k]);
			repeat (6) @(posedge clk);
			chk("burst words", 32'(CntTab[k]), 32'(wordCnt - n));
		end
		done("clocked");
		wr(ADDR_CTRL, CTRL_RST);
		wr(ADDR_PAT, 32'h0001_0001);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_TRIG, TrigTab[k]);
			wr(ADDR_TLIM, TlimTab[k]);
			i_lpb_far_logic.setLines(16'h0000);
			repeat (30) @(posedge clk);
			n = trigCnt;
			i_lpb_far_logic.setLines(16'h0001);
			repeat (10) @(posedge clk);
			i_lpb_far_logic.setLines(16'h0000);
			repeat (30) @(posedge clk);
			chk("triggers", 32'h1, 32'(trigCnt - n));
		end
		// low level moved into the band, then above it: state holds, then rises
		lvlLo <= 11'h08a;
		lvl(11'h0c8, 16'h0000);
		lvlLo <= 11'h091;
		lvl(11'h0c8, 16'hffff);
		done("trigger");
		final_report();
	end
endmodule : logic_parallel_bus_decoder_tb
`default_nettype wire
